/* File: design/bst_top.v */
// burst trigger playback, exported start trigger and data mask stage
`timescale 1ns/10ps
`default_nettype none
`include "bst_regs.vh"

module bst_top (
	input  wire        clk,
	input  wire        resetn,
	input  wire        ce,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [31:0] wb_dat_i,
	input  wire [3:0]  wb_sel_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        start_trig_in,
	output wire        start_trig_out,
	output reg  [15:0] dac_data,
	output reg         dac_valid,
	input  wire        dac_ready,
	output reg  [15:0] dig_data,
	output reg         running
);
	localparam ST_IDLE = 2'b01;
	localparam ST_PLAY = 2'b10;

	// control and settings
	reg  [9:0]  ctrl_reg;
	reg  [15:0] amask_reg;
	reg  [15:0] astatic_reg;
	reg  [15:0] dmask_reg;
	reg  [15:0] dstatic_reg;
	reg  [1:0]  seg_last_reg;
	reg  [5:0]  waddr_reg;
	reg  [13:0] seg_tab_reg [0:3];
	reg  [15:0] wave_reg [0:`BST_WAVE_DEPTH-1];
	reg  [7:0]  acc_cnt_reg;
	reg  [7:0]  ign_cnt_reg;

	// playback
	reg  [1:0]  state_reg;
	reg  [1:0]  seg_idx_reg;
	reg  [5:0]  ptr_reg;
	reg         pending_reg;
	reg  [7:0]  lat_reg;
	reg  [15:0] prev_reg;

	// trigger input and export pulse
	reg         trig_s1_reg;
	reg         trig_s2_reg;
	reg         trig_s3_reg;
	reg         exp_pulse_reg;

	wire        arm;
	wire        seq;
	wire        trig_edge;
	wire        bus_req;
	wire        wr_en;
	wire [13:0] seg_cur;
	wire [13:0] seg_nxt_ent;
	wire [1:0]  seg_nxt;
	wire [5:0]  cur_start;
	wire [5:0]  cur_last;
	wire        at_last;
	wire        f_in_valid;
	wire        f_in_ready;
	wire        f_out_valid;
	wire        f_out_ready;
	wire [15:0] f_out_data;
	wire        push;
	wire        switching;
	wire        start_now;
	wire        lat_done;
	wire [7:0]  lat_calc;
	wire [7:0]  dflt_lat;
	wire [16:0] avg_sum;
	wire [15:0] filt;
	wire        flush;

	assign arm     = ctrl_reg[`BST_CTRL_ARM];
	assign seq     = ctrl_reg[`BST_CTRL_SEQ];
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_en   = bus_req & wb_we_i;

	function [15:0] merge;
		input [15:0] old;
		input [15:0] nw;
		input [1:0]  sel;
		integer      i;
		begin
			merge = old;
			for (i = 0; i < 2; i = i + 1) begin
				if (sel[i]) begin
					merge[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	// pin is asynchronous; the second and third stages feed the edge detector
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			trig_s1_reg <= 1'b0;
			trig_s2_reg <= 1'b0;
			trig_s3_reg <= 1'b0;
		end else if (ce) begin
			trig_s1_reg <= start_trig_in;
			trig_s2_reg <= trig_s1_reg;
			trig_s3_reg <= trig_s2_reg;
		end
	end

	assign trig_edge = trig_s2_reg & ~trig_s3_reg;

	// segment table lookup
	assign seg_cur     = seg_tab_reg[seg_idx_reg];
	assign seg_nxt     = (seg_idx_reg == seg_last_reg) ? 2'b00
	                     : seg_idx_reg + 2'b01;
	assign seg_nxt_ent = seg_tab_reg[seg_nxt];
	assign cur_start   = seg_cur[`BST_SEG_START_HI:0];
	assign cur_last    = seg_cur[`BST_SEG_LAST_HI:`BST_SEG_LAST_LO];
	assign at_last     = (ptr_reg == cur_last);

	assign start_now  = (state_reg == ST_IDLE) & arm & trig_edge;
	assign f_in_valid = (state_reg == ST_PLAY);
	assign push       = f_in_valid & f_in_ready;
	// a trigger in the very cycle the waveform ends still counts as late
	assign switching  = push & at_last & pending_reg & seq;
	assign flush      = ~arm;

	// extra latency per enabled stage; interpolation scales the filter delay
	assign dflt_lat = `BST_LAT_DFLT << ctrl_reg[`BST_CTRL_INTERP_HI:
	                                            `BST_CTRL_INTERP_LO];
	assign lat_calc = `BST_LAT_BASE
	                + (ctrl_reg[`BST_CTRL_DFLT] ? dflt_lat : 8'h00)
	                + (ctrl_reg[`BST_CTRL_AFLT] ? `BST_LAT_AFLT : 8'h00)
	                + (ctrl_reg[`BST_CTRL_DSP] ? `BST_LAT_DSP : 8'h00);
	assign lat_done = (lat_reg == 8'h00);

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg     <= ST_IDLE;
			seg_idx_reg   <= 2'b00;
			ptr_reg       <= 6'h00;
			pending_reg   <= 1'b0;
			lat_reg       <= 8'h00;
			exp_pulse_reg <= 1'b0;
			acc_cnt_reg   <= 8'h00;
			ign_cnt_reg   <= 8'h00;
		end else if (ce) begin
			exp_pulse_reg <= start_now;
			if (!lat_done) begin
				lat_reg <= lat_reg - 8'h01;
			end
			case (state_reg)
			ST_IDLE: begin
				pending_reg <= 1'b0;
				if (start_now) begin
					state_reg   <= ST_PLAY;
					seg_idx_reg <= 2'b00;
					ptr_reg     <= seg_tab_reg[0][`BST_SEG_START_HI:0];
					lat_reg     <= lat_calc;
					acc_cnt_reg <= acc_cnt_reg + 8'h01;
				end
			end
			ST_PLAY: begin
				if (!arm) begin
					state_reg <= ST_IDLE;
				end else begin
					if (switching) begin
						seg_idx_reg <= seg_nxt;
						ptr_reg     <= seg_nxt_ent[`BST_SEG_START_HI:0];
					end else if (push && at_last) begin
						ptr_reg <= cur_start;
					end else if (push) begin
						ptr_reg <= ptr_reg + 6'h01;
					end
					if (trig_edge && seq && !pending_reg && !switching) begin
						pending_reg <= 1'b1;
						acc_cnt_reg <= acc_cnt_reg + 8'h01;
					end else begin
						if (switching) begin
							pending_reg <= 1'b0;
						end
						if (trig_edge) begin
							ign_cnt_reg <= ign_cnt_reg + 8'h01;
						end
					end
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	bst_fifo #(
		.W  (`BST_SAMPLE_W),
		.D  (`BST_FIFO_DEPTH),
		.AW (3)
	) u_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.ce        (ce),
		.flush     (flush),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (wave_reg[ptr_reg]),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data)
	);

	// drain held back until the start latency has run out
	assign f_out_ready = lat_done & (state_reg == ST_PLAY) &
	                     (~dac_valid | dac_ready);

	// two-tap average; interpolation only shows up as delay
	assign avg_sum = {1'b0, f_out_data} + {1'b0, prev_reg};
	assign filt    = ctrl_reg[`BST_CTRL_DFLT] ? avg_sum[16:1]
	                 : f_out_data;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dac_data  <= 16'h0000;
			dig_data  <= 16'h0000;
			dac_valid <= 1'b0;
			prev_reg  <= 16'h0000;
			running   <= 1'b0;
		end else if (ce) begin
			running <= (state_reg == ST_PLAY);
			if (flush) begin
				dac_valid <= 1'b0;
				prev_reg  <= 16'h0000;
			end else if (f_out_valid && f_out_ready) begin
				prev_reg  <= f_out_data;
				dac_data  <= (filt & amask_reg)
				           | (~amask_reg & astatic_reg);
				dig_data  <= (f_out_data & dmask_reg)
				           | (~dmask_reg & dstatic_reg);
				dac_valid <= 1'b1;
			end else if (dac_ready) begin
				dac_valid <= 1'b0;
			end
		end
	end

	bst_stretch #(
		.DLY (`BST_EXP_DLY_CYC),
		.MIN (`BST_EXP_MIN_CYC)
	) u_exp (
		.clk     (clk),
		.resetn  (resetn),
		.ce      (ce),
		.pulse   (exp_pulse_reg),
		.out_reg (start_trig_out)
	);

	// wishbone register file; wave memory kept out of reset on purpose
	always @(posedge clk) begin
		if (ce && wr_en && wb_adr_i == `BST_ADR_WDATA) begin
			wave_reg[waddr_reg] <= merge(wave_reg[waddr_reg],
			                             wb_dat_i[15:0], wb_sel_i[1:0]);
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg       <= `BST_CTRL_RST;
			amask_reg      <= `BST_MASK_RST;
			astatic_reg    <= `BST_STATIC_RST;
			dmask_reg      <= `BST_MASK_RST;
			dstatic_reg    <= `BST_STATIC_RST;
			seg_last_reg   <= 2'b00;
			waddr_reg      <= 6'h00;
			seg_tab_reg[0] <= `BST_SEG_RST;
			seg_tab_reg[1] <= `BST_SEG_RST;
			seg_tab_reg[2] <= `BST_SEG_RST;
			seg_tab_reg[3] <= `BST_SEG_RST;
			wb_ack_o       <= 1'b0;
			wb_dat_o       <= 32'h00000000;
		end else if (ce) begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
				`BST_ADR_CTRL:    wb_dat_o <= {22'h000000, ctrl_reg};
				`BST_ADR_STATUS:  wb_dat_o <= {27'h0000000, lat_done,
				                              seg_idx_reg, pending_reg,
				                              state_reg[1]};
				`BST_ADR_AMASK:   wb_dat_o <= {16'h0000, amask_reg};
				`BST_ADR_ASTATIC: wb_dat_o <= {16'h0000, astatic_reg};
				`BST_ADR_DMASK:   wb_dat_o <= {16'h0000, dmask_reg};
				`BST_ADR_DSTATIC: wb_dat_o <= {16'h0000, dstatic_reg};
				`BST_ADR_SEGCNT:  wb_dat_o <= {30'h00000000, seg_last_reg};
				`BST_ADR_WADDR:   wb_dat_o <= {26'h0000000, waddr_reg};
				`BST_ADR_WDATA:   wb_dat_o <= {16'h0000, wave_reg[waddr_reg]};
				`BST_ADR_TRIGCNT: wb_dat_o <= {16'h0000, ign_cnt_reg,
				                              acc_cnt_reg};
				default: begin
					if (wb_adr_i >= `BST_ADR_SEG0 &&
					    wb_adr_i <= `BST_ADR_SEG3 &&
					    wb_adr_i[1:0] == 2'b00) begin
						wb_dat_o <= {18'h00000, seg_tab_reg[wb_adr_i[3:2]]};
					end else begin
						wb_dat_o <= 32'h00000000;
					end
				end
				endcase
			end
			if (wr_en) begin
				case (wb_adr_i)
				`BST_ADR_CTRL: ctrl_reg <= {wb_sel_i[1] ? wb_dat_i[9:8] : ctrl_reg[9:8],
					wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_reg[7:0]};
				`BST_ADR_AMASK: amask_reg <=
					merge(amask_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
				`BST_ADR_ASTATIC: astatic_reg <=
					merge(astatic_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
				`BST_ADR_DMASK: dmask_reg <=
					merge(dmask_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
				`BST_ADR_DSTATIC: dstatic_reg <=
					merge(dstatic_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
				`BST_ADR_SEGCNT: begin
					if (wb_sel_i[0]) begin
						seg_last_reg <= wb_dat_i[1:0];
					end
				end
				`BST_ADR_WADDR: begin
					if (wb_sel_i[0]) begin
						waddr_reg <= wb_dat_i[5:0];
					end
				end
				`BST_ADR_WDATA: waddr_reg <= waddr_reg + 6'h01;
				default: begin
					if (wb_adr_i >= `BST_ADR_SEG0 &&
					    wb_adr_i <= `BST_ADR_SEG3 &&
					    wb_adr_i[1:0] == 2'b00) begin
						seg_tab_reg[wb_adr_i[3:2]] <= {
							wb_sel_i[1] ? wb_dat_i[13:8] : seg_tab_reg[wb_adr_i[3:2]][13:8],
							2'b00, wb_sel_i[0] ? wb_dat_i[5:0] : seg_tab_reg[wb_adr_i[3:2]][5:0]};
					end
				end
				endcase
			end
		end
	end
endmodule // bst_top
`default_nettype wire

/* File: include/bst_regs.vh */
// register map, field positions, reset values and timing counts
`ifndef BST_REGS_VH
`define BST_REGS_VH

`define BST_ADR_CTRL       8'h00
`define BST_ADR_STATUS     8'h04
`define BST_ADR_AMASK      8'h08
`define BST_ADR_ASTATIC    8'h0c
`define BST_ADR_DMASK      8'h10
`define BST_ADR_DSTATIC    8'h14
`define BST_ADR_SEGCNT     8'h18
`define BST_ADR_WADDR      8'h1c
`define BST_ADR_WDATA      8'h20
`define BST_ADR_TRIGCNT    8'h24
`define BST_ADR_SEG0       8'h40
`define BST_ADR_SEG3       8'h4c

`define BST_CTRL_ARM       0
`define BST_CTRL_SEQ       1
`define BST_CTRL_DFLT      2
`define BST_CTRL_AFLT      3
`define BST_CTRL_DSP       4
`define BST_CTRL_INTERP_LO 8
`define BST_CTRL_INTERP_HI 9

`define BST_SEG_START_HI   5
`define BST_SEG_LAST_LO    8
`define BST_SEG_LAST_HI    13

`define BST_CTRL_RST       10'h000
`define BST_MASK_RST       16'hffff
`define BST_STATIC_RST     16'h0000
`define BST_SEG_RST        14'h3f00

`define BST_CLK_NS         10
`define BST_EXP_MIN_NS     150
`define BST_EXP_MIN_CYC    ((`BST_EXP_MIN_NS + `BST_CLK_NS - 1) / `BST_CLK_NS)
`define BST_EXP_DLY_CYC    3
`define BST_LAT_BASE       8'h04
`define BST_LAT_DFLT       8'h04
`define BST_LAT_AFLT       8'h06
`define BST_LAT_DSP        8'h08

`define BST_WAVE_DEPTH     64
`define BST_FIFO_DEPTH     8
`define BST_SAMPLE_W       16

`endif

/* File: design/bst_fifo.v */
// sample fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module bst_fifo #(
	parameter W  = 16,
	parameter D  = 8,
	parameter AW = 3
) (
	input  wire         clk,
	input  wire         resetn,
	input  wire         ce,
	input  wire         flush,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem_reg [0:D-1];
	reg [AW:0]  wr_ptr_reg;
	reg [AW:0]  rd_ptr_reg;
	wire        empty;
	wire        full;
	wire        push;
	wire        pop;

	assign empty     = (wr_ptr_reg == rd_ptr_reg);
	assign full      = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
	                   (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];
	assign push      = in_valid & ~full;
	assign pop       = out_ready & ~empty;

	always @(posedge clk) begin
		if (ce && push && !flush) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_reg <= {(AW+1){1'b0}};
			rd_ptr_reg <= {(AW+1){1'b0}};
		end else if (ce) begin
			if (flush) begin
				wr_ptr_reg <= {(AW+1){1'b0}};
				rd_ptr_reg <= {(AW+1){1'b0}};
			end else begin
				if (push) begin
					wr_ptr_reg <= wr_ptr_reg + {{AW{1'b0}}, 1'b1};
				end
				if (pop) begin
					rd_ptr_reg <= rd_ptr_reg + {{AW{1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // bst_fifo
`default_nettype wire

/* File: design/bst_stretch.v */
// delays a one-cycle pulse and stretches it to a least width
`timescale 1ns/10ps
`default_nettype none
module bst_stretch #(
	parameter DLY = 3,
	parameter MIN = 15
) (
	input  wire clk,
	input  wire resetn,
	input  wire ce,
	input  wire pulse,
	output reg  out_reg
);
	reg [DLY-1:0] dly_reg;
	reg [7:0]     cnt_reg;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dly_reg <= {DLY{1'b0}};
			cnt_reg <= 8'h00;
			out_reg <= 1'b0;
		end else if (ce) begin
			dly_reg <= {dly_reg[DLY-2:0], pulse};
			if (dly_reg[DLY-1]) begin
				cnt_reg <= MIN[7:0] - 8'h01;
				out_reg <= 1'b1;
			end else if (cnt_reg != 8'h00) begin
				cnt_reg <= cnt_reg - 8'h01;
			end else begin
				out_reg <= 1'b0;
			end
		end
	end
endmodule // bst_stretch
`default_nettype wire

/* File: verification/bst_top_assertions.sv */
// port-level checks for the burst playback top
`timescale 1ns/10ps
`default_nettype none
`include "bst_regs.vh"
module bst_top_assertions (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        ce,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        start_trig_in,
	input wire logic        start_trig_out,
	input wire logic [15:0] dac_data,
	input wire logic        dac_valid,
	input wire logic        dac_ready,
	input wire logic [15:0] dig_data,
	input wire logic        running
);
	logic [15:0] am_reg, as_reg, dm_reg, ds_reg;
	logic [7:0]  hi_reg, age_reg, ctl_reg;
	logic        pin_reg;
	wire         wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce
		&& wb_sel_i == 4'hf;
	// mask mirrors: masked-off output bits must equal the static bits
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			am_reg <= `BST_MASK_RST;
			dm_reg <= `BST_MASK_RST;
			as_reg <= `BST_STATIC_RST;
			ds_reg <= `BST_STATIC_RST;
			hi_reg <= 8'h00;
			age_reg <= 8'hff;
			ctl_reg <= 8'hff;
			pin_reg <= 1'b0;
		end else begin
			if (wr && wb_adr_i == `BST_ADR_AMASK) am_reg <= wb_dat_i[15:0];
			if (wr && wb_adr_i == `BST_ADR_ASTATIC) as_reg <= wb_dat_i[15:0];
			if (wr && wb_adr_i == `BST_ADR_DMASK) dm_reg <= wb_dat_i[15:0];
			if (wr && wb_adr_i == `BST_ADR_DSTATIC) ds_reg <= wb_dat_i[15:0];
			hi_reg <= start_trig_out ? hi_reg + {7'h0, hi_reg != 8'hff} : 8'h0;
			age_reg <= (start_trig_in && !pin_reg) ? 8'h0
				: age_reg + {7'h0, age_reg != 8'hff};
			ctl_reg <= (wr && wb_adr_i == `BST_ADR_CTRL) ? 8'h0
				: ctl_reg + {7'h0, ctl_reg != 8'hff};
			pin_reg <= start_trig_in;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence wb_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
	endsequence
	ack_next_a: assert property (wb_req |=> wb_ack_o)
		else $error("ack not one cycle after request");
	ack_pulse_a: assert property (wb_ack_o && ce |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	export_width_a: assert property ($fell(start_trig_out) |-> hi_reg >= 8'd15)
		else $error("exported trigger too short");
	export_cause_a: assert property ($rose(start_trig_out) |-> running && age_reg inside {[3:16]})
		else $error("exported trigger without recent start");
	run_hold_a: assert property ($fell(running) |-> ctl_reg < 8'd8)
		else $error("playback stopped without disarm");
	valid_run_a: assert property ($rose(dac_valid) |-> running)
		else $error("samples while idle");
	amask_bits_a: assert property (dac_valid |-> ((dac_data ^ as_reg) & ~am_reg) == 16'h0)
		else $error("analog static bits wrong");
	dmask_bits_a: assert property (dac_valid |-> ((dig_data ^ ds_reg) & ~dm_reg) == 16'h0)
		else $error("digital static bits wrong");
	valid_hold_a: assert property (dac_valid && !dac_ready && ctl_reg > 8'd8
		|=> dac_valid && $stable(dac_data))
		else $error("sample dropped before taken");
endmodule // bst_top_assertions
bind bst_top bst_top_assertions u_chk (.clk(clk), .resetn(resetn), .ce(ce),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .start_trig_in(start_trig_in),
	.start_trig_out(start_trig_out), .dac_data(dac_data),
	.dac_valid(dac_valid), .dac_ready(dac_ready), .dig_data(dig_data),
	.running(running));
`default_nettype wire

/* File: verification/bst_partner.sv */
// far side: start trigger source and converter sample sink
`timescale 1ns/10ps
`default_nettype none
module bst_partner (
	input  wire logic        clk,
	input  wire logic        stall,
	input  wire logic        slow,
	input  wire logic        dac_valid,
	input  wire logic [15:0] dac_data,
	output var  logic        dac_ready,
	output var  logic        start_trig_in
);
	logic [15:0] got[$];
	logic        ph_reg;
	initial begin
		dac_ready = 1'b0;
		start_trig_in = 1'b0;
		ph_reg = 1'b0;
	end
	// slow mode takes every other cycle to expose backpressure paths
	always @(posedge clk) begin
		ph_reg <= !ph_reg;
		dac_ready <= !stall && (!slow || ph_reg);
		if (dac_valid && dac_ready) got.push_back(dac_data);
	end
	// held 3 cycles high, 3 low: one clean edge through the synchroniser
	task automatic fire();
		@(posedge clk);
		start_trig_in <= 1'b1;
		repeat (3) @(posedge clk);
		start_trig_in <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
endmodule // bst_partner
`default_nettype wire

/* File: verification/test_bst_top.sv */
// self-checking bench for playback, trigger export and masks
`timescale 1ns/10ps
`default_nettype none
`include "bst_regs.vh"
module test_bst_top;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d, e;} bst_row_t;
	logic        clk = 1'b0, resetn = 1'b0, ce = 1'b1, cyc = 1'b0;
	logic        stb = 1'b0, we = 1'b0, stall = 1'b0, slow = 1'b0;
	logic        tro_reg = 1'b0, ok;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'hf;
	logic [15:0] p, v;
	logic [31:0] wdat = 32'h0, rd, cnt;
	wire  [31:0] dat_o;
	wire  [15:0] dac_data, dig_data;
	wire         ack, trig_in, trig_out, dac_valid, dac_ready, running;
	int          fails = 0, compares = 0, exp_n = 0, n, adv, lat[5];
	logic [9:0]  cfg[5] = '{10'h001, 10'h005, 10'h105, 10'h009, 10'h011};
	int          dlt[5] = '{0, 4, 8, 6, 8};
	bst_row_t    rows[12] = '{
		'{1'b0, `BST_ADR_CTRL, 32'h0, 32'h0},
		'{1'b0, `BST_ADR_AMASK, 32'h0, 32'hffff},
		'{1'b0, `BST_ADR_DSTATIC, 32'h0, 32'h0},
		'{1'b0, `BST_ADR_SEG3, 32'h0, 32'h3f00},
		'{1'b1, 8'h80, 32'hffffffff, 32'h0},
		'{1'b0, 8'h80, 32'h0, 32'h0},
		'{1'b1, `BST_ADR_STATUS, 32'h1f, 32'h0},
		'{1'b0, `BST_ADR_STATUS, 32'h0, 32'h10},
		'{1'b1, `BST_ADR_AMASK, 32'hff00, 32'h0},
		'{1'b1, `BST_ADR_ASTATIC, 32'haaaa, 32'h0},
		'{1'b1, `BST_ADR_DSTATIC, 32'h5555, 32'h0},
		'{1'b0, `BST_ADR_AMASK, 32'h0, 32'hff00}};
	always #5 clk = ~clk;
	bst_top u_dut (.clk(clk), .resetn(resetn), .ce(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.start_trig_in(trig_in), .start_trig_out(trig_out),
		.dac_data(dac_data), .dac_valid(dac_valid), .dac_ready(dac_ready),
		.dig_data(dig_data), .running(running));
	bst_partner u_far (.clk(clk), .stall(stall), .slow(slow),
		.dac_valid(dac_valid), .dac_data(dac_data), .dac_ready(dac_ready),
		.start_trig_in(trig_in));
	always @(posedge clk) begin
		tro_reg <= trig_out;
		if (trig_out && !tro_reg) exp_n++;
	end
	task automatic chk(input logic [31:0] g, e, input string m);
		compares++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask
	// entered just after an edge; holds the request until ack is seen
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 20) chk(32'h0, 32'h1, "no ack");
		@(posedge clk);
	endtask
	task automatic finish_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		finish_test();
	end
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			bus(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk(rd, rows[i].e, "register");
		end
		$display("test registers done");
		bus(1'b1, `BST_ADR_DMASK, 32'h00ff);
		bus(1'b1, `BST_ADR_WADDR, 32'h0);
		for (int i = 0; i < `BST_WAVE_DEPTH; i++)
			bus(1'b1, `BST_ADR_WDATA, 32'h1111);
		for (int i = 0; i < 5; i++) begin
			u_far.got.delete();
			bus(1'b1, `BST_ADR_CTRL, {22'h0, cfg[i]});
			fork
				u_far.fire();
			join_none
			n = 0;
			for (int j = 0; j < 400 && dac_valid !== 1'b1; j++) begin
				@(posedge clk);
				if (running === 1'b1) n++;
			end
			lat[i] = n;
			if (i == 1) begin
				repeat (4) @(posedge clk);
				chk({16'h0, u_far.got[0]}, 32'h08aa, "filtered");
			end
			if (i == 0) begin
				repeat (20) @(posedge clk);
				bus(1'b0, `BST_ADR_TRIGCNT, 32'h0);
				cnt = rd;
				u_far.fire();
				repeat (20) @(posedge clk);
				bus(1'b0, `BST_ADR_TRIGCNT, 32'h0);
				chk(rd - cnt, 32'h100, "late trigger");
				cnt = rd;
				ce <= 1'b0;
				u_far.fire();
				ce <= 1'b1;
				bus(1'b0, `BST_ADR_TRIGCNT, 32'h0);
				chk(rd, cnt, "frozen trigger");
				chk({31'h0, running}, 32'h1, "playing");
				chk({16'h0, u_far.got[0]}, 32'h11aa, "analog");
				chk({16'h0, dig_data}, 32'h5511, "digital");
			end
			bus(1'b1, `BST_ADR_CTRL, 32'h0);
		end
		chk(exp_n, 5, "exports");
		for (int i = 1; i < 5; i++)
			chk(lat[i] - lat[0], dlt[i], "latency");
		$display("test single done");
		bus(1'b1, `BST_ADR_AMASK, 32'hffff);
		bus(1'b1, `BST_ADR_WADDR, 32'h0);
		for (int i = 0; i < 6; i++) bus(1'b1, `BST_ADR_WDATA, 32'h0a00 + i);
		for (int i = 0; i < 3; i++)
			bus(1'b1, 8'(`BST_ADR_SEG0 + 4 * i), 32'h101 * (2 * i) + 32'h100);
		bus(1'b1, `BST_ADR_SEGCNT, 32'h2);
		bus(1'b0, `BST_ADR_TRIGCNT, 32'h0);
		cnt = rd;
		stall <= 1'b1;
		u_far.got.delete();
		bus(1'b1, `BST_ADR_CTRL, 32'h3);
		u_far.fire();
		repeat (30) @(posedge clk);
		u_far.fire();
		bus(1'b0, `BST_ADR_STATUS, 32'h0);
		chk({31'h0, rd[1]}, 32'h1, "pending set");
		u_far.fire();
		bus(1'b0, `BST_ADR_TRIGCNT, 32'h0);
		chk(rd - cnt, 32'h102, "pending trigger");
		stall <= 1'b0;
		slow <= 1'b1;
		repeat (40) @(posedge clk);
		bus(1'b0, `BST_ADR_STATUS, 32'h0);
		chk({31'h0, rd[1]}, 32'h0, "pending clear");
		repeat (3) begin
			u_far.fire();
			repeat (40) @(posedge clk);
		end
		stall <= 1'b1;
		repeat (4) @(posedge clk);
		chk({16'h0, u_far.got[0]}, 32'h0a00, "first");
		adv = 0;
		for (int k = 1; k < u_far.got.size(); k++) begin
			p = u_far.got[k - 1];
			v = u_far.got[k];
			ok = v[15:4] == 12'h0a0 && (p[0] ? (v == p - 1 ||
				v == (p == 16'h0a05 ? 16'h0a00 : p + 1)) : v == p + 1);
			if (p[0] && v != p - 1) adv++;
			chk({31'h0, ok}, 32'h1, "order");
		end
		chk(adv, 4, "advances");
		$display("test sequence done");
		bus(1'b1, `BST_ADR_ASTATIC, 32'h1234);
		resetn <= 1'b0;
		@(posedge clk);
		chk({29'h0, running, dac_valid, trig_out}, 32'h0, "in reset");
		@(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		bus(1'b0, `BST_ADR_AMASK, 32'h0);
		chk(rd, 32'hffff, "mask after reset");
		bus(1'b0, `BST_ADR_ASTATIC, 32'h0);
		chk(rd, 32'h0, "static after reset");
		$display("test reset done");
		finish_test();
	end
endmodule // test_bst_top
`default_nettype wire
